// ===== core/radio_timer_pkg.sv
package radio_timer_pkg;
  // clock rate in MHz, 100 ns period
  localparam int CLK_MHZ = 10;
  // transition times in microseconds, as printed
  localparam int WAKE_US = 420;
  localparam int WAKE_MAX_US = 1000;
  localparam int RESET_US = 26;
  localparam int SHORT_US = 1;
  localparam int INIT_LOCK_US = 170;
  localparam int INIT_LOCK_MAX_US = 370;
  localparam int CHAN_US = 11;
  localparam int CAL_US = 8;
  localparam int TX_RX_US = 32;
  localparam int RX_TX_US = 16;
  localparam int RND_US = 1;
  // signal-strength refresh per modulation
  localparam int RSSI_B20_US = 32;
  localparam int RSSI_B40_US = 24;
  localparam int RSSI_OQ_US = 8;
  // symbol periods per modulation
  localparam int SYM_B20_US = 50;
  localparam int SYM_B40_US = 25;
  localparam int SYM_OQ_US = 16;
  localparam int MEAS_SYMBOLS = 8;
  // derived cycle counts
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam logic [15:0] RESET_CYC = 16'(RESET_US * CLK_MHZ);
  localparam logic [15:0] SHORT_CYC = 16'(SHORT_US * CLK_MHZ);
  localparam logic [15:0] INIT_CYC = 16'(INIT_LOCK_US * CLK_MHZ);
  localparam logic [15:0] CHAN_CYC = 16'(CHAN_US * CLK_MHZ);
  localparam logic [15:0] CAL_CYC = 16'(CAL_US * CLK_MHZ);
  localparam logic [15:0] TX_RX_CYC = 16'(TX_RX_US * CLK_MHZ);
  localparam logic [15:0] RX_TX_CYC = 16'(RX_TX_US * CLK_MHZ);
  localparam logic [15:0] RND_CYC = 16'(RND_US * CLK_MHZ);
  // register byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_CFG = 8'h08;
  localparam logic [7:0] A_IRQ = 8'h0c;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_MEAS = 8'h14;
  localparam logic [7:0] A_CHAN = 8'h18;
  localparam logic [7:0] A_CAL = 8'h1c;
  localparam logic [7:0] A_DATA = 8'h20;
  // state report codes
  localparam logic [4:0] C_TX = 5'h02;
  localparam logic [4:0] C_RX = 5'h06;
  localparam logic [4:0] C_IDLE = 5'h08;
  localparam logic [4:0] C_PLL = 5'h09;
  localparam logic [4:0] C_SLEEP = 5'h0f;
  localparam logic [4:0] C_AACK = 5'h16;
  localparam logic [4:0] C_ARET = 5'h19;
  localparam logic [4:0] C_PEND = 5'h1f;
  // state commands
  localparam logic [4:0] CMD_NOP = 5'h00;
  localparam logic [4:0] CMD_SEND = 5'h02;
  localparam logic [4:0] CMD_FIDLE = 5'h03;
  localparam logic [4:0] CMD_FPLL = 5'h04;
  localparam logic [4:0] CMD_RX = 5'h06;
  localparam logic [4:0] CMD_IDLE = 5'h08;
  localparam logic [4:0] CMD_PLL = 5'h09;
  localparam logic [4:0] CMD_AACK = 5'h16;
  localparam logic [4:0] CMD_ARET = 5'h19;
  // modulation select
  localparam logic [1:0] MODE_B20 = 2'h0;
  localparam logic [1:0] MODE_B40 = 2'h1;
  localparam logic [1:0] MODE_RST = 2'h2;
  // interrupt bit positions
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_TXEND = 1;
  localparam int IRQ_SCAN = 2;
  localparam int IRQ_CCA = 3;

  typedef enum logic [2:0] {
    st_reset, st_sleep, st_idle, st_pll, st_rx, st_aack, st_aret, st_tx
  } radio_state_type;

  // one symbol period in cycles
  function automatic logic [15:0] sym_cycles(logic [1:0] m);
    if (m == MODE_B20) return 16'(SYM_B20_US * CLK_MHZ);
    if (m == MODE_B40) return 16'(SYM_B40_US * CLK_MHZ);
    return 16'(SYM_OQ_US * CLK_MHZ);
  endfunction

  // signal-strength refresh period in cycles
  function automatic logic [15:0] rssi_cycles(logic [1:0] m);
    if (m == MODE_B20) return 16'(RSSI_B20_US * CLK_MHZ);
    if (m == MODE_B40) return 16'(RSSI_B40_US * CLK_MHZ);
    return 16'(RSSI_OQ_US * CLK_MHZ);
  endfunction
endpackage

// ===== core/periodic_tick.sv
`timescale 1ns/100ps
// one-cycle enable every period cycles while run is high
module periodic_tick #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic tick
);
  logic [W-1:0] cnt; // cycles since last tick
  logic [W-1:0] next_cnt;

  if (W < 2) begin : g_chk
    $error("periodic_tick needs W of at least 2");
  end

  // a stopped timer restarts from zero, so phase follows run
  always_comb begin
    next_cnt = cnt + W'(1);
    if (!run || cnt >= period - W'(1)) begin
      next_cnt = '0;
    end
  end

  assign tick = run && (cnt >= period - W'(1));

  // counter register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ===== core/radio_state_timer.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
module radio_state_timer #(
  parameter int WAKE_CYCLES = radio_timer_pkg::WAKE_CYC,
  parameter logic [7:0] CCA_LIMIT = 8'h40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_tx_pin,
  input wire logic tx_frame_end,
  input wire logic [7:0] rssi_level,
  output logic irq
);
  typedef radio_timer_pkg::radio_state_type state_type;

  typedef struct packed {
    state_type cur; // settled state
    state_type dest; // target of a pending move
    logic pending; // transition under way
    logic [15:0] cnt; // transition down-counter
    logic rx_after; // listen once the frame ends
    logic [4:0] last_cmd; // last command written
    logic [1:0] mode; // modulation select
    logic [3:0] irq; // sticky events
    logic [3:0] mask; // event enables
    logic [2:0] pin_sync; // pin synchroniser
    logic pin_lvl; // filtered pin level
    logic scan_on; // energy scan running
    logic cca_on; // assessment running
    logic [2:0] sym_cnt; // symbols measured
    logic [10:0] acc; // strength sum
    logic [7:0] energy; // last scan or assessment result
    logic cca_done; // assessment finished
    logic cca_status; // channel found idle
    logic [7:0] rssi; // latest strength
    logic [15:0] rnd; // random value
    logic [7:0] chan; // channel number
    logic [31:0] prdata; // read data
    logic pslverr; // unmapped address
  } regs_type;

  regs_type r;
  regs_type next_r;
  logic us_tick; // microsecond enable
  logic rssi_tick; // strength refresh enable
  logic sym_tick; // symbol enable while measuring
  logic pin_rise; // filtered pin edge
  logic wr; // write in access phase
  logic [4:0] report; // visible state code
  logic [15:0] sym_len; // symbol length now

  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_chk
    $error("WAKE_CYCLES must fit the 16-bit counter");
  end

  // load a timed transition toward d
  function automatic regs_type go(regs_type s, state_type d,
                                  logic [15:0] c);
    s.pending = 1'b1;
    s.dest = d;
    s.cnt = c;
    return s;
  endfunction

  // clocked radio states that accept routine moves
  function automatic logic live(state_type s);
    return s == radio_timer_pkg::st_pll || s == radio_timer_pkg::st_rx ||
           s == radio_timer_pkg::st_aack || s == radio_timer_pkg::st_aret;
  endfunction

  // receive states
  function automatic logic listening(state_type s);
    return s == radio_timer_pkg::st_rx || s == radio_timer_pkg::st_aack;
  endfunction

  // code for a settled state
  function automatic logic [4:0] code(state_type s);
    unique case (s)
      radio_timer_pkg::st_reset: return radio_timer_pkg::C_PEND;
      radio_timer_pkg::st_sleep: return radio_timer_pkg::C_SLEEP;
      radio_timer_pkg::st_idle: return radio_timer_pkg::C_IDLE;
      radio_timer_pkg::st_pll: return radio_timer_pkg::C_PLL;
      radio_timer_pkg::st_rx: return radio_timer_pkg::C_RX;
      radio_timer_pkg::st_aack: return radio_timer_pkg::C_AACK;
      radio_timer_pkg::st_aret: return radio_timer_pkg::C_ARET;
      radio_timer_pkg::st_tx: return radio_timer_pkg::C_TX;
    endcase
  endfunction

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign sym_len = radio_timer_pkg::sym_cycles(r.mode);
  assign report = r.pending ? radio_timer_pkg::C_PEND : code(r.cur);
  assign irq = |(r.irq & r.mask);
  // edge counts only once second and third stages agree
  assign pin_rise = (r.pin_sync[1] == r.pin_sync[2]) && r.pin_sync[2] &&
                    !r.pin_lvl;

  // microsecond enable for the random value
  periodic_tick #(.W(16)) u_us_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(1'b1),
    .period(radio_timer_pkg::RND_CYC),
    .tick(us_tick)
  );

  // strength refresh only in settled receive states
  periodic_tick #(.W(16)) u_rssi_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(listening(r.cur) && !r.pending),
    .period(radio_timer_pkg::rssi_cycles(r.mode)),
    .tick(rssi_tick)
  );

  // symbol pacing for scan and assessment
  periodic_tick #(.W(16)) u_sym_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(r.scan_on || r.cca_on),
    .period(sym_len),
    .tick(sym_tick)
  );

  // next-state logic for the whole block
  always_comb begin
    next_r = r;
    // bus clears come first so a same-cycle event wins
    if (wr && paddr == radio_timer_pkg::A_IRQ) begin
      next_r.irq = r.irq & ~pwdata[3:0];
    end
    if (wr && paddr == radio_timer_pkg::A_MASK) begin
      next_r.mask = pwdata[3:0];
    end
    if (wr && paddr == radio_timer_pkg::A_CFG) begin
      next_r.mode = pwdata[1:0];
    end
    // stage 0 feeds only stage 1
    next_r.pin_sync = {r.pin_sync[1:0], sleep_tx_pin};
    if (r.pin_sync[1] == r.pin_sync[2]) begin
      next_r.pin_lvl = r.pin_sync[2];
    end
    if (us_tick) begin
      next_r.rnd = {r.rnd[14:0],
                    ~(r.rnd[15] ^ r.rnd[13] ^ r.rnd[12] ^ r.rnd[10])};
    end
    if (rssi_tick) begin
      next_r.rssi = rssi_level;
    end
    // transition counter, completes on reaching zero
    if (r.pending) begin
      if (r.cnt <= 16'h0001) begin
        next_r.cnt = '0;
        next_r.pending = 1'b0;
        next_r.cur = r.dest;
        if (r.cur == radio_timer_pkg::st_sleep) begin
          next_r.irq[radio_timer_pkg::IRQ_WAKE] = 1'b1;
        end
      end else begin
        next_r.cnt = r.cnt - 16'h0001;
      end
    end
    // frame end: settle back to lock or listen
    if (r.cur == radio_timer_pkg::st_tx && !r.pending && tx_frame_end) begin
      next_r = go(next_r, r.rx_after ? radio_timer_pkg::st_rx :
                  radio_timer_pkg::st_pll, radio_timer_pkg::TX_RX_CYC);
      next_r.rx_after = 1'b0;
      next_r.irq[radio_timer_pkg::IRQ_TXEND] = 1'b1;
    end
    // pin: sleep from idle, wake from sleep, send from lock
    if (!r.pending) begin
      if (r.cur == radio_timer_pkg::st_idle && r.pin_lvl) begin
        next_r.cur = radio_timer_pkg::st_sleep;
      end else if (r.cur == radio_timer_pkg::st_sleep && !r.pin_lvl) begin
        next_r = go(next_r, radio_timer_pkg::st_idle,
                    16'(WAKE_CYCLES));
      end else if (r.cur == radio_timer_pkg::st_pll && pin_rise) begin
        next_r = go(next_r, radio_timer_pkg::st_tx, sym_len);
      end
    end
    // state command decode
    if (wr && paddr == radio_timer_pkg::A_CMD) begin
      next_r.last_cmd = pwdata[4:0];
      unique case (pwdata[4:0])
        radio_timer_pkg::CMD_FIDLE: begin
          // forced idle overrides even a pending move
          if (r.cur != radio_timer_pkg::st_sleep &&
              r.cur != radio_timer_pkg::st_reset) begin
            next_r = go(next_r, radio_timer_pkg::st_idle,
                        radio_timer_pkg::SHORT_CYC);
            next_r.rx_after = 1'b0; // stale listen request dies here
          end
        end
        radio_timer_pkg::CMD_FPLL: begin
          // not while unclocked or heading to idle or sleep
          if ((live(r.cur) || r.cur == radio_timer_pkg::st_tx) &&
              !(r.pending && r.dest == radio_timer_pkg::st_idle)) begin
            next_r = go(next_r, radio_timer_pkg::st_pll,
                        radio_timer_pkg::SHORT_CYC);
            next_r.rx_after = 1'b0;
          end
        end
        radio_timer_pkg::CMD_SEND: begin
          if (!r.pending && r.cur == radio_timer_pkg::st_pll) begin
            next_r = go(next_r, radio_timer_pkg::st_tx, sym_len);
          end else if (!r.pending && r.cur == radio_timer_pkg::st_rx) begin
            next_r = go(next_r, radio_timer_pkg::st_tx,
                        radio_timer_pkg::RX_TX_CYC + sym_len);
          end
        end
        radio_timer_pkg::CMD_RX: begin
          if (r.cur == radio_timer_pkg::st_tx ||
              (r.pending && r.dest == radio_timer_pkg::st_tx)) begin
            next_r.rx_after = 1'b1;
          end else if (!r.pending && r.cur == radio_timer_pkg::st_idle) begin
            next_r = go(next_r, radio_timer_pkg::st_rx,
                        radio_timer_pkg::INIT_CYC);
          end else if (!r.pending && r.cur == radio_timer_pkg::st_pll) begin
            next_r = go(next_r, radio_timer_pkg::st_rx,
                        radio_timer_pkg::SHORT_CYC);
          end
        end
        radio_timer_pkg::CMD_PLL: begin
          if (!r.pending && r.cur == radio_timer_pkg::st_idle) begin
            next_r = go(next_r, radio_timer_pkg::st_pll,
                        radio_timer_pkg::INIT_CYC);
          end else if (!r.pending && live(r.cur) &&
                       r.cur != radio_timer_pkg::st_pll) begin
            next_r = go(next_r, radio_timer_pkg::st_pll,
                        radio_timer_pkg::SHORT_CYC);
          end
        end
        radio_timer_pkg::CMD_IDLE: begin
          if (!r.pending && live(r.cur)) begin
            next_r = go(next_r, radio_timer_pkg::st_idle,
                        radio_timer_pkg::SHORT_CYC);
          end
        end
        radio_timer_pkg::CMD_AACK, radio_timer_pkg::CMD_ARET: begin
          if (!r.pending && r.cur == radio_timer_pkg::st_pll) begin
            next_r = go(next_r, pwdata[4:0] == radio_timer_pkg::CMD_AACK ?
                        radio_timer_pkg::st_aack : radio_timer_pkg::st_aret,
                        radio_timer_pkg::SHORT_CYC);
          end
        end
        default: begin
          // no-op and reserved codes start nothing
        end
      endcase
    end
    // channel change and calibration hold the state pending
    if (wr && paddr == radio_timer_pkg::A_CHAN) begin
      next_r.chan = pwdata[7:0];
      if (!r.pending && live(r.cur)) begin
        next_r = go(next_r, r.cur, radio_timer_pkg::CHAN_CYC);
      end
    end
    if (wr && paddr == radio_timer_pkg::A_CAL && pwdata[0] &&
        !r.pending && live(r.cur)) begin
      next_r = go(next_r, r.cur, radio_timer_pkg::CAL_CYC);
    end
    // measurement start, only while listening
    if (wr && paddr == radio_timer_pkg::A_MEAS && !r.pending &&
        listening(r.cur) && pwdata[1:0] != 2'h0) begin
      next_r.scan_on = pwdata[0];
      next_r.cca_on = pwdata[1];
      next_r.sym_cnt = '0;
      next_r.acc = '0;
      next_r.cca_done = 1'b0;
    end
    // average eight symbol samples
    if (sym_tick) begin
      next_r.acc = r.acc + {3'h0, r.rssi};
      next_r.sym_cnt = r.sym_cnt + 3'h1;
      if (r.sym_cnt == 3'(radio_timer_pkg::MEAS_SYMBOLS - 1)) begin
        next_r.energy = next_r.acc[10:3];
        next_r.scan_on = 1'b0;
        next_r.cca_on = 1'b0;
        if (r.scan_on) begin
          next_r.irq[radio_timer_pkg::IRQ_SCAN] = 1'b1;
        end
        if (r.cca_on) begin
          next_r.cca_done = 1'b1;
          next_r.cca_status = next_r.acc[10:3] < CCA_LIMIT;
          next_r.irq[radio_timer_pkg::IRQ_CCA] = 1'b1;
        end
      end
    end
    // leaving receive aborts a measurement
    if (!listening(r.cur) || r.pending) begin
      next_r.scan_on = 1'b0;
      next_r.cca_on = 1'b0;
    end
    // read data captured in the setup phase
    if (psel && !penable) begin
      next_r.pslverr = 1'b0;
      unique case (paddr)
        radio_timer_pkg::A_STATUS:
          next_r.prdata = {24'h0, r.cca_done, r.cca_status, 1'b0, report};
        radio_timer_pkg::A_CMD: next_r.prdata = {27'h0, r.last_cmd};
        radio_timer_pkg::A_CFG: next_r.prdata = {30'h0, r.mode};
        radio_timer_pkg::A_IRQ: next_r.prdata = {28'h0, r.irq};
        radio_timer_pkg::A_MASK: next_r.prdata = {28'h0, r.mask};
        radio_timer_pkg::A_MEAS:
          next_r.prdata = {30'h0, r.cca_on, r.scan_on};
        radio_timer_pkg::A_CHAN: next_r.prdata = {24'h0, r.chan};
        radio_timer_pkg::A_CAL: next_r.prdata = 32'h0;
        radio_timer_pkg::A_DATA:
          next_r.prdata = {r.rnd, r.energy, r.rssi};
        default: begin
          next_r.prdata = 32'h0;
          next_r.pslverr = 1'b1;
        end
      endcase
    end
  end

  // state register; reset walks to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.pending <= 1'b1;
      r.dest <= radio_timer_pkg::st_idle;
      r.cnt <= radio_timer_pkg::RESET_CYC;
      r.mode <= radio_timer_pkg::MODE_RST;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pend_code_a: assert property (
    psel && !penable && paddr == radio_timer_pkg::A_STATUS && r.pending |=>
    prdata[4:0] == 5'h1f)
    else $error("pending state not reported as 0x1f");
  wake_load_a: assert property (
    !r.pending && r.cur == radio_timer_pkg::st_sleep && !r.pin_lvl |=>
    r.pending && r.cnt == 16'(WAKE_CYCLES))
    else $error("sleep exit did not load wake time");
  wake_irq_a: assert property (
    r.pending && r.cur == radio_timer_pkg::st_sleep && r.cnt == 16'h1 |=>
    r.irq[0] && r.cur == radio_timer_pkg::st_idle)
    else $error("wake end did not raise wake irq");
  lock_time_a: assert property (
    !r.pending && r.cur == radio_timer_pkg::st_rx && wr &&
    paddr == radio_timer_pkg::A_CMD &&
    pwdata[4:0] == radio_timer_pkg::CMD_PLL |=> r.cnt == 16'd10)
    else $error("listen to lock not 1 us");
  send_wait_a: assert property (
    !r.pending && r.cur == radio_timer_pkg::st_pll && pin_rise && !wr |=>
    r.dest == radio_timer_pkg::st_tx && r.cnt == $past(sym_len))
    else $error("send wait not one symbol");
  force_skip_a: assert property (
    !r.pending && r.cur == radio_timer_pkg::st_idle && wr &&
    paddr == radio_timer_pkg::A_CMD &&
    pwdata[4:0] == radio_timer_pkg::CMD_FPLL |=> !r.pending)
    else $error("forced lock accepted in idle");
  init_lock_a: assert property (
    !r.pending && r.cur == radio_timer_pkg::st_idle && wr &&
    paddr == radio_timer_pkg::A_CMD &&
    pwdata[4:0] == radio_timer_pkg::CMD_PLL |=> r.cnt == 16'd1700)
    else $error("initial lock not 170 us");
  tx_back_a: assert property (
    !r.pending && r.cur == radio_timer_pkg::st_tx && tx_frame_end &&
    !(wr && paddr == radio_timer_pkg::A_CMD) |=>
    r.pending && r.cnt == 16'd320 && r.dest == $past(r.rx_after ?
    radio_timer_pkg::st_rx : radio_timer_pkg::st_pll))
    else $error("frame end settle wrong");
  report_switch_a: assert property (
    r.pending && r.cnt == 16'h1 |=> !r.pending && report != 5'h1f)
    else $error("report did not switch at zero");
  rnd_step_a: assert property (us_tick |=> r.rnd != $past(r.rnd))
    else $error("random value not refreshed");

  wake_c: cover property (r.irq[0] && r.cur == radio_timer_pkg::st_idle);
  send_c: cover property (r.cur == radio_timer_pkg::st_tx && tx_frame_end);
  cca_c: cover property ($rose(r.cca_done));
  chan_c: cover property (r.pending && r.cnt == radio_timer_pkg::CHAN_CYC);
endmodule

// ===== dv/frame_model.sv
`timescale 1ns/100ps
// far-side radio: ends a frame a fixed time after go, moves strength
module frame_model #(
  parameter int FRAME = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  output logic tx_frame_end,
  output logic [7:0] rssi_level
);
  int cnt; // cycles left in the frame, 0 when idle

  // one-cycle end pulse; strength never sits still, so no stale match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      tx_frame_end <= 1'b0;
      rssi_level <= 8'h00;
    end else begin
      rssi_level <= rssi_level + 8'h03;
      tx_frame_end <= (cnt == 1);
      if (go) begin
        cnt <= FRAME;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ===== dv/radio_state_timer_tb.sv
`timescale 1ns/100ps
// self-checking bench: host side over apb, frame model on the far side
module radio_state_timer_tb;
  logic pclk, presetn, psel, penable, pwrite, sleep_tx_pin, go;
  logic pready, pslverr, irq, tx_frame_end, rd_err;
  logic [7:0] paddr, rssi_level;
  logic [31:0] pwdata, prdata, rd_data;
  int num_errors = 0;
  int num_checks = 0;
  int sym[3] = '{500, 250, 160}; // symbol cycles per mode

  // short wake count keeps the run brief
  radio_state_timer #(.WAKE_CYCLES(50)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_tx_pin(sleep_tx_pin),
    .tx_frame_end(tx_frame_end), .rssi_level(rssi_level), .irq(irq));
  frame_model #(.FRAME(40)) far (.pclk(pclk), .presetn(presetn),
    .go(go), .tx_frame_end(tx_frame_end), .rssi_level(rssi_level));

  task automatic chk(input string name, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one apb transfer; idle cycle at the end avoids double drive of psel
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // entered one edge after the start edge: pending late, new code after
  task automatic after(input int n, input logic [4:0] code);
    repeat (n - 4) @(posedge pclk);
    apb(1'b0, radio_timer_pkg::A_STATUS, 32'h0);
    chk("status pending", rd_data & 32'h1f, 32'(radio_timer_pkg::C_PEND));
    apb(1'b0, radio_timer_pkg::A_STATUS, 32'h0);
    chk("status final", rd_data & 32'h1f, 32'(code));
  endtask

  task automatic t_bus;
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped error", {31'h0, rd_err}, 32'h1);
    apb(1'b1, radio_timer_pkg::A_CMD, 32'(radio_timer_pkg::CMD_FPLL));
    repeat (10) @(posedge pclk);
    apb(1'b0, radio_timer_pkg::A_STATUS, 32'h0);
    chk("forced lock ignored", rd_data & 32'h1f, 32'h08);
  endtask

  task automatic cmd(input logic [7:0] a, input logic [31:0] d, input int n,
                     input logic [4:0] code);
    apb(1'b1, a, d);
    after(n, code);
  endtask

  task automatic t_moves;
    cmd(radio_timer_pkg::A_CMD, 32'h09, 1700, radio_timer_pkg::C_PLL);
    cmd(radio_timer_pkg::A_CMD, 32'h06, 10, radio_timer_pkg::C_RX);
    cmd(radio_timer_pkg::A_CMD, 32'h09, 10, radio_timer_pkg::C_PLL);
    cmd(radio_timer_pkg::A_CHAN, 32'h05, 110, radio_timer_pkg::C_PLL);
    cmd(radio_timer_pkg::A_CAL, 32'h01, 80, radio_timer_pkg::C_PLL);
  endtask

  // send in every mode; last one asks for listen while sending
  task automatic t_send;
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, radio_timer_pkg::A_CFG, 32'(m));
      cmd(radio_timer_pkg::A_CMD, 32'h02, sym[m], radio_timer_pkg::C_TX);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      if (m == 2) begin
        apb(1'b1, radio_timer_pkg::A_CMD, 32'h06);
      end
      do @(posedge pclk); while (tx_frame_end !== 1'b1);
      @(posedge pclk);
      after(320, m == 2 ? radio_timer_pkg::C_RX : radio_timer_pkg::C_PLL);
    end
  endtask

  // sleep by pin, wake with irq masked, then unmask and clear
  task automatic t_sleep;
    sleep_tx_pin <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, radio_timer_pkg::A_STATUS, 32'h0);
    chk("asleep", rd_data & 32'h1f, 32'h0f);
    sleep_tx_pin <= 1'b0;
    repeat (70) @(posedge pclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b0, radio_timer_pkg::A_STATUS, 32'h0);
    chk("awake idle", rd_data & 32'h1f, 32'h08);
    apb(1'b0, radio_timer_pkg::A_IRQ, 32'h0);
    chk("wake flag", rd_data & 32'h1, 32'h1);
    apb(1'b1, radio_timer_pkg::A_MASK, 32'h1);
    chk("irq unmasked", {31'h0, irq}, 32'h1);
    apb(1'b1, radio_timer_pkg::A_IRQ, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
  endtask

  // pin edge in lock starts a send; forced lock brings it back
  task automatic t_pin;
    sleep_tx_pin <= 1'b1;
    repeat (5) @(posedge pclk);
    after(sym[2], radio_timer_pkg::C_TX);
    sleep_tx_pin <= 1'b0;
    cmd(radio_timer_pkg::A_CMD, 32'h04, 10, radio_timer_pkg::C_PLL);
  endtask

  // listen: measure, strength and random refresh, then send and stop
  task automatic t_listen;
    logic [31:0] d0;
    apb(1'b1, radio_timer_pkg::A_MEAS, 32'h3);
    repeat (1270) @(posedge pclk);
    apb(1'b0, radio_timer_pkg::A_MEAS, 32'h0);
    chk("measuring", rd_data, 32'h3);
    repeat (8) @(posedge pclk);
    apb(1'b0, radio_timer_pkg::A_MEAS, 32'h0);
    chk("measure done", rd_data, 32'h0);
    apb(1'b0, radio_timer_pkg::A_STATUS, 32'h0);
    chk("cca done", rd_data & 32'h80, 32'h80);
    apb(1'b0, radio_timer_pkg::A_IRQ, 32'h0);
    chk("scan and cca flags", rd_data & 32'hc, 32'hc);
    apb(1'b0, radio_timer_pkg::A_DATA, 32'h0);
    d0 = rd_data;
    repeat (77) @(posedge pclk);
    apb(1'b0, radio_timer_pkg::A_DATA, 32'h0);
    chk("strength moved", {31'h0, rd_data[7:0] != d0[7:0]}, 32'h1);
    chk("random moved", {31'h0, rd_data[31:16] != d0[31:16]}, 32'h1);
    cmd(radio_timer_pkg::A_CMD, 32'h02, 160 + sym[2],
        radio_timer_pkg::C_TX);
    cmd(radio_timer_pkg::A_CMD, 32'h03, 10, radio_timer_pkg::C_IDLE);
  endtask

  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // free-running 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // hang guard, well beyond the ~6000 cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    end_sim;
  end

  // host never commands while pending: each step waits its full time
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_tx_pin = 1'b0;
    go = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    after(260, radio_timer_pkg::C_IDLE);
    t_bus;
    t_moves;
    t_pin;
    t_send;
    t_listen;
    t_sleep;
    end_sim;
  end
endmodule
